//--- rtl/telemetry_decommutator.sv
// Purpose: Telemetry decommutator: frame lock, channel checks, tagged output words
// Assumes: One 100 MHz clock; word and preamble strobes arrive from pins
// Notes:   Limit tables must be loaded before the limit check is enabled
`include "telemetry_decommutator_consts.svh"

// Function
// - Input word 24 bits: value in seven low bits, lock in top bit.
// - Every word sync captures a word; a preamble in the same cycle still arms the next word.
// - Keep previous value per channel location and detect changes.
// - Compare each channel word with stored limits; alarm when outside.
// - Seven per-type tables, each as long as its frame format.
// - Word after preamble sync is the data type; select its table.
// - Preamble suppresses frame-sync search for scan and flare types.
// - While locked outside modes three and four, the preamble check is skipped.
// - Mode to type map: I-A, II-B, III-C/D, IV-A/E/F, V-D, VI-G.
// - Two classes: engineering-class types versus scan and flare types.
// - Engineering class searches for frame sync, seven ones.
// - Word after sync is the mode word; check it, pick frame layout. The code only checks it; frame length follows the data type.
// - With subcommutation, read medium and low deck words; load counters.
// - Keep lock through one or two consecutive framing errors, configurable.
// - Each framing word error sets its own condition flag; data kept.
// - Search continuously in engineering data; not inside capsule or science.
// - Scan and flare framed without deck words; scan output kept separate.
// - Outputs are 24-bit words, binary or BCD per user, three users.
// - Checkout word starts with five status flags.
// - Engineering-class channels get addresses and a flag field or indicator.
// - Checkout word: ten address bits, then nine BCD data bits.
// - Engineering host word: limit bit, OR of last four flags, 9 address, 7 data.
module telemetry_decommutator (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Demodulator side
   input wire logic [23:0] word_in,
   input wire logic word_sync,
   input wire logic preamble_sync,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Checkout equipment output
   output logic [23:0] checkout_word,
   output logic checkout_valid,
   // Host data system output
   output logic [23:0] host_word,
   output logic host_valid,
   output logic host_scan,
   // Test console output
   output logic [23:0] console_word,
   output logic console_valid,
   // Status
   output logic frame_locked,
   output logic out_of_limit_alarm
);

   // ==========================================================
   // Declarations
   logic [23:0] word_m_r, word_s_r;
   logic ws_m_r, ws_s_r, ws_d_r;
   logic ps_m_r, ps_s_r, ps_d_r;
   logic word_evt, preamble_evt;
   logic [6:0] val;
   logic demod_lock_indicator;
   logic pre_pend_r, pre_ok;
   logic [2:0] dtype_r;
   logic scan_flare_class_data, engineering_class_data;
   telemetry_decommutator_pkg::framer_state_t state_r;
   logic [6:0] pos_r, frame_len;
   logic lock_r, frame_bad_r, deck_ref_r;
   logic [1:0] err_cnt_r;
   logic [2:0] mode_r;
   logic mode_chg_r;
   logic [3:0] data_condition_flag;
   logic [6:0] medium_deck_position, low_deck_position;
   logic fw_err, mode_good, lose_lock;
   logic [2:0] err_sum;
   logic [`TD_CTRL_W-1:0] ctrl_r;
   logic [9:0] lim_idx_r;
   logic [6:0] lo_mem [0:1023];
   logic [6:0] hi_mem [0:1023];
   logic [6:0] prev_mem [0:1023];
   logic [9:0] chan_idx;
   logic chan_evt, changed, limit_bad, alarm;
   logic [4:0] flags;
   logic cond_ind;
   logic [8:0] bcd;
   logic [6:0] data_host, data_console;

   // ==========================================================
   // Pin synchronisers, two flops each
   always_ff @(posedge clock) begin
      if (!resetn) begin
         word_m_r <= 24'h000000;
         word_s_r <= 24'h000000;
         ws_m_r <= 1'b0;
         ws_s_r <= 1'b0;
         ws_d_r <= 1'b0;
         ps_m_r <= 1'b0;
         ps_s_r <= 1'b0;
         ps_d_r <= 1'b0;
      end else begin
         word_m_r <= word_in;
         word_s_r <= word_m_r;
         ws_m_r <= word_sync;
         ws_s_r <= ws_m_r;
         ws_d_r <= ws_s_r;
         ps_m_r <= preamble_sync;
         ps_s_r <= ps_m_r;
         ps_d_r <= ps_s_r;
      end
   end

   // Strobe edges; the data word rides the same delay as its strobe
   assign word_evt = ws_s_r & ~ws_d_r;
   assign preamble_evt = ps_s_r & ~ps_d_r;
   assign val = word_s_r[`TD_VAL_MSB:0];
   assign demod_lock_indicator = word_s_r[`TD_LOCK_BIT];

   // ==========================================================
   // Type classes and layout lookups
   assign scan_flare_class_data = (dtype_r == `TD_TYPE_C) || (dtype_r == `TD_TYPE_F);
   assign engineering_class_data = !scan_flare_class_data;

   // Frame length of the selected table
   always_comb begin
      unique case (dtype_r)
         `TD_TYPE_A: frame_len = `TD_LEN_A;
         `TD_TYPE_B: frame_len = `TD_LEN_B;
         `TD_TYPE_C: frame_len = `TD_LEN_C;
         `TD_TYPE_D: frame_len = `TD_LEN_D;
         `TD_TYPE_E: frame_len = `TD_LEN_E;
         `TD_TYPE_F: frame_len = `TD_LEN_F;
         `TD_TYPE_G: frame_len = `TD_LEN_G;
         default: frame_len = `TD_LEN_A;
      endcase
   end

   // Mode word consistent with the data type
   always_comb begin
      unique case (val[2:0])
         `TD_MODE_I: mode_good = dtype_r == `TD_TYPE_A;
         `TD_MODE_II: mode_good = dtype_r == `TD_TYPE_B;
         `TD_MODE_III: mode_good = (dtype_r == `TD_TYPE_C) || (dtype_r == `TD_TYPE_D);
         `TD_MODE_IV: mode_good = (dtype_r == `TD_TYPE_A) || (dtype_r == `TD_TYPE_E) ||
                                  (dtype_r == `TD_TYPE_F);
         `TD_MODE_V: mode_good = dtype_r == `TD_TYPE_D;
         `TD_MODE_VI: mode_good = dtype_r == `TD_TYPE_G;
         default: mode_good = 1'b0;
      endcase
   end

   // ==========================================================
   // Preamble and data type capture
   assign pre_ok = !lock_r || (mode_r == `TD_MODE_III) || (mode_r == `TD_MODE_IV);

   always_ff @(posedge clock) begin
      if (!resetn) begin
         pre_pend_r <= 1'b0;
         dtype_r <= `TD_TYPE_A;
      end else begin
         // A preamble coinciding with a word arms the next word
         if (word_evt && pre_pend_r) begin
            pre_pend_r <= 1'b0;
            if (val[2:0] != `TD_TYPE_INVALID) begin
               dtype_r <= val[2:0];
            end
         end
         if (preamble_evt && pre_ok) begin
            pre_pend_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Framing word errors and flywheel
   always_comb begin
      fw_err = 1'b0;
      if (lock_r && word_evt && !pre_pend_r) begin
         unique case (state_r)
            telemetry_decommutator_pkg::ST_SYNC: fw_err = val != `TD_SYNC_WORD;
            telemetry_decommutator_pkg::ST_MODE: fw_err = !mode_good;
            telemetry_decommutator_pkg::ST_MEDIUM_DECK_POSITION: fw_err = deck_ref_r &&
               (val != ((medium_deck_position == `TD_MS_LEN - 7'h01) ? 7'h00 : medium_deck_position + 7'h01));
            telemetry_decommutator_pkg::ST_LOW_DECK_POSITION: fw_err = deck_ref_r &&
               (val != ((low_deck_position == `TD_LS_LEN - 7'h01) ? 7'h00 : low_deck_position + 7'h01));
            default: fw_err = 1'b0;
         endcase
      end
   end

   // One tolerated error, or two when configured
   assign err_sum = {1'b0, err_cnt_r} + 3'h1;
   assign lose_lock = fw_err && (err_sum > (ctrl_r[`TD_CTRL_TOL2] ? 3'h2 : 3'h1));

   // ==========================================================
   // Framer state machine
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_r <= telemetry_decommutator_pkg::ST_HUNT;
         pos_r <= 7'h00;
         lock_r <= 1'b0;
         frame_bad_r <= 1'b0;
         deck_ref_r <= 1'b0;
         err_cnt_r <= 2'h0;
         mode_r <= 3'h0;
         mode_chg_r <= 1'b0;
         data_condition_flag <= 4'h0;
         medium_deck_position <= 7'h00;
         low_deck_position <= 7'h00;
      end else if (word_evt && pre_pend_r) begin
         // Data type word: restart framing under the new table
         data_condition_flag <= 4'h0;
         err_cnt_r <= 2'h0;
         deck_ref_r <= 1'b0;
         pos_r <= 7'h00;
         if (val[2:0] == `TD_TYPE_C || val[2:0] == `TD_TYPE_F) begin
            state_r <= telemetry_decommutator_pkg::ST_DATA;
            lock_r <= 1'b1;
         end else begin
            state_r <= telemetry_decommutator_pkg::ST_HUNT;
            lock_r <= 1'b0;
         end
      end else if (word_evt) begin
         if (fw_err) begin
            err_cnt_r <= err_sum[1:0];
            frame_bad_r <= 1'b1;
         end
         unique case (state_r)
            telemetry_decommutator_pkg::ST_HUNT: begin
               // Search every word unless scan or flare is running
               if (!scan_flare_class_data && val == `TD_SYNC_WORD) begin
                  state_r <= telemetry_decommutator_pkg::ST_MODE;
                  pos_r <= `TD_POS_MODE;
                  data_condition_flag <= 4'h0;
               end
            end
            telemetry_decommutator_pkg::ST_SYNC: begin
               // Locked: sync only checked in its own slot
               data_condition_flag <= {3'h0, fw_err};
               frame_bad_r <= fw_err;
               if (!frame_bad_r && !fw_err) begin
                  err_cnt_r <= 2'h0;
               end
               pos_r <= pos_r + 7'h01;
               state_r <= telemetry_decommutator_pkg::ST_MODE;
            end
            telemetry_decommutator_pkg::ST_MODE: begin
               if (!lock_r) begin
                  if (mode_good) begin
                     mode_r <= val[2:0];
                     mode_chg_r <= 1'b0;
                     lock_r <= 1'b1;
                     frame_bad_r <= 1'b0;
                     pos_r <= pos_r + 7'h01;
                     state_r <= telemetry_decommutator_pkg::ST_MEDIUM_DECK_POSITION;
                  end else begin
                     state_r <= telemetry_decommutator_pkg::ST_HUNT;
                  end
               end else begin
                  data_condition_flag[1] <= fw_err;
                  if (mode_good) begin
                     mode_chg_r <= val[2:0] != mode_r;
                     mode_r <= val[2:0];
                  end
                  pos_r <= pos_r + 7'h01;
                  state_r <= telemetry_decommutator_pkg::ST_MEDIUM_DECK_POSITION;
               end
            end
            telemetry_decommutator_pkg::ST_MEDIUM_DECK_POSITION: begin
               data_condition_flag[2] <= fw_err;
               medium_deck_position <= val;
               pos_r <= pos_r + 7'h01;
               state_r <= telemetry_decommutator_pkg::ST_LOW_DECK_POSITION;
            end
            telemetry_decommutator_pkg::ST_LOW_DECK_POSITION: begin
               data_condition_flag[3] <= fw_err;
               low_deck_position <= val;
               deck_ref_r <= 1'b1;
               pos_r <= pos_r + 7'h01;
               state_r <= telemetry_decommutator_pkg::ST_DATA;
            end
            telemetry_decommutator_pkg::ST_DATA: begin
               if (pos_r >= frame_len - 7'h01) begin
                  pos_r <= 7'h00;
                  if (engineering_class_data) begin
                     state_r <= telemetry_decommutator_pkg::ST_SYNC;
                  end
               end else begin
                  pos_r <= pos_r + 7'h01;
               end
            end
            default: state_r <= telemetry_decommutator_pkg::ST_HUNT;
         endcase
         // Flywheel exhausted: drop lock and hunt again
         if (lose_lock) begin
            state_r <= telemetry_decommutator_pkg::ST_HUNT;
            lock_r <= 1'b0;
            deck_ref_r <= 1'b0;
            err_cnt_r <= 2'h0;
         end
      end
   end

   // ==========================================================
   // Channel checks
   assign chan_evt = word_evt && !pre_pend_r && (state_r == telemetry_decommutator_pkg::ST_DATA);
   assign chan_idx = {dtype_r, pos_r};
   assign changed = val != prev_mem[chan_idx];
   assign limit_bad = (val < lo_mem[chan_idx]) || (val > hi_mem[chan_idx]);
   assign alarm = (ctrl_r[`TD_CTRL_LIMIT_EN] && limit_bad) || (ctrl_r[`TD_CTRL_DELTA_EN] && changed);
   // Status flags: limit, mode changed, low deck, medium deck, sync
   assign flags = {alarm, mode_chg_r | data_condition_flag[1], data_condition_flag[3],
                   data_condition_flag[2], data_condition_flag[0] | !demod_lock_indicator};
   assign cond_ind = |flags[3:0];

   // Binary to three BCD digits, hundreds digit one bit wide
   function automatic logic [8:0] to_bcd(input logic [6:0] v);
      logic h;
      logic [6:0] r;
      h = v >= `TD_BCD_HUNDRED;
      r = h ? v - `TD_BCD_HUNDRED : v;
      return {h, 4'(r / `TD_BCD_TEN), 4'(r % `TD_BCD_TEN)};
   endfunction

   assign bcd = to_bcd(val);
   assign data_host = ctrl_r[`TD_CTRL_BCD_HOST] ? bcd[6:0] : val;
   assign data_console = ctrl_r[`TD_CTRL_BCD_CONSOLE] ? bcd[6:0] : val;

   // Previous value per channel location
   always_ff @(posedge clock) begin
      if (chan_evt) begin
         prev_mem[chan_idx] <= val;
      end
   end

   // ==========================================================
   // Output words
   always_ff @(posedge clock) begin
      if (!resetn) begin
         checkout_word <= 24'h000000;
         checkout_valid <= 1'b0;
         host_word <= 24'h000000;
         host_valid <= 1'b0;
         host_scan <= 1'b0;
         console_word <= 24'h000000;
         console_valid <= 1'b0;
         out_of_limit_alarm <= 1'b0;
      end else begin
         checkout_valid <= chan_evt && engineering_class_data;
         host_valid <= chan_evt;
         console_valid <= chan_evt;
         out_of_limit_alarm <= chan_evt && alarm;
         if (chan_evt) begin
            host_scan <= scan_flare_class_data;
            // Flags, ten-bit address, nine data bits
            checkout_word <= {flags, chan_idx,
                              ctrl_r[`TD_CTRL_BCD_CHECKOUT] ? bcd : {2'h0, val}};
            if (engineering_class_data) begin
               host_word <= {alarm, cond_ind, {2'h0, pos_r}, data_host, {3'h0, dtype_r}};
               console_word <= {alarm, cond_ind, {2'h0, pos_r}, data_console, {3'h0, dtype_r}};
            end else begin
               host_word <= {cond_ind, chan_idx, data_host, {3'h0, dtype_r}};
               console_word <= {cond_ind, chan_idx, data_console, {3'h0, dtype_r}};
            end
         end
      end
   end

   assign frame_locked = lock_r;

   // ==========================================================
   // Register port: control and limit index
   always_ff @(posedge clock) begin
      if (!resetn) begin
         ctrl_r <= `TD_CTRL_RESET;
         lim_idx_r <= 10'h000;
      end else if (reg_wr) begin
         if (reg_addr == `TD_REG_CTRL) begin
            ctrl_r <= reg_wdata[`TD_CTRL_W-1:0];
         end
         if (reg_addr == `TD_REG_LIM_INDEX) begin
            lim_idx_r <= reg_wdata[9:0];
         end
         if (reg_addr == `TD_REG_LIM_DATA) begin
            lim_idx_r <= lim_idx_r + 10'h001;
         end
      end
   end

   // Limit tables, low limit in bits 6:0, high limit in bits 13:7
   always_ff @(posedge clock) begin
      if (reg_wr && reg_addr == `TD_REG_LIM_DATA) begin
         lo_mem[lim_idx_r] <= reg_wdata[6:0];
         hi_mem[lim_idx_r] <= reg_wdata[13:7];
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (!resetn) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `TD_REG_CTRL: reg_rdata <= {26'h0000000, ctrl_r};
            `TD_REG_STATUS: reg_rdata <= {18'h00000, pre_pend_r, err_cnt_r, data_condition_flag,
                                          mode_r, dtype_r, lock_r};
            `TD_REG_LIM_INDEX: reg_rdata <= {22'h000000, lim_idx_r};
            `TD_REG_LIM_DATA: reg_rdata <= {18'h00000, hi_mem[lim_idx_r], lo_mem[lim_idx_r]};
            default: reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule

//--- rtl/telemetry_decommutator_consts.svh
// Purpose: Named constants of the telemetry decommutator
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only
`ifndef TELEMETRY_DECOMMUTATOR_CONSTS_SVH
`define TELEMETRY_DECOMMUTATOR_CONSTS_SVH

// ==========================================================
// Input word layout
`define TD_LOCK_BIT 23
`define TD_VAL_MSB 6
`define TD_SYNC_WORD 7'h7f
`define TD_TYPE_INVALID 3'h7

// ==========================================================
// Data type codes
`define TD_TYPE_A 3'h0
`define TD_TYPE_B 3'h1
`define TD_TYPE_C 3'h2
`define TD_TYPE_D 3'h3
`define TD_TYPE_E 3'h4
`define TD_TYPE_F 3'h5
`define TD_TYPE_G 3'h6

// ==========================================================
// Data mode codes
`define TD_MODE_I 3'h1
`define TD_MODE_II 3'h2
`define TD_MODE_III 3'h3
`define TD_MODE_IV 3'h4
`define TD_MODE_V 3'h5
`define TD_MODE_VI 3'h6

// ==========================================================
// Frame lengths per data type, framing words included
`define TD_LEN_A 7'h2e
`define TD_LEN_B 7'h46
`define TD_LEN_C 7'h40
`define TD_LEN_D 7'h5a
`define TD_LEN_E 7'h40
`define TD_LEN_F 7'h40
`define TD_LEN_G 7'h46
`define TD_POS_MODE 7'h01
`define TD_POS_MEDIUM_DECK_POSITION 7'h02
`define TD_POS_LOW_DECK_POSITION 7'h03

// ==========================================================
// Deck lengths
`define TD_MS_LEN 7'h0a
`define TD_LS_LEN 7'h14

// ==========================================================
// Register map and control bits
`define TD_REG_CTRL 8'h00
`define TD_REG_STATUS 8'h04
`define TD_REG_LIM_INDEX 8'h08
`define TD_REG_LIM_DATA 8'h0c
`define TD_CTRL_TOL2 0
`define TD_CTRL_LIMIT_EN 1
`define TD_CTRL_DELTA_EN 2
`define TD_CTRL_BCD_CHECKOUT 3
`define TD_CTRL_BCD_HOST 4
`define TD_CTRL_BCD_CONSOLE 5
`define TD_CTRL_W 6
`define TD_CTRL_RESET 6'h08
`define TD_BCD_HUNDRED 7'h64
`define TD_BCD_TEN 7'h0a

`endif

//--- rtl/telemetry_decommutator_pkg.sv
// Purpose: Types of the telemetry decommutator
// Assumes: Constants come from telemetry_decommutator_consts.svh
// Notes:   Used by scope, never imported
package telemetry_decommutator_pkg;
   // Framer states
   typedef enum logic [2:0] {
      ST_HUNT,
      ST_SYNC,
      ST_MODE,
      ST_MEDIUM_DECK_POSITION,
      ST_LOW_DECK_POSITION,
      ST_DATA
   } framer_state_t;
endpackage

//--- sim/demod_model.sv
// Purpose: Behavioural telemetry demodulator driving word and preamble pins
// Assumes: Strobes last four clocks, word held three clocks before and one clock after
// Notes:   Released word lines are inverted so stale values never match
module demod_model (
   // Clock
   input wire logic clock,
   // Demodulator pins
   output logic [23:0] word_in,
   output logic word_sync,
   output logic preamble_sync
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Idle pins
   initial begin
      word_in = 24'h0;
      word_sync = 1'b0;
      preamble_sync = 1'b0;
   end
   // One word: lock flag on top, value low, spare bits busy
   task automatic send(input logic lock, input logic [6:0] val);
      word_in <= {lock, 16'ha5c3, val};
      repeat (3) @(posedge clock);
      word_sync <= 1'b1;
      repeat (4) @(posedge clock);
      word_sync <= 1'b0;
      @(posedge clock);
      word_in <= ~word_in;
      repeat (2) @(posedge clock);
   endtask
   // Preamble strobe ahead of a type word
   task automatic mark();
      repeat (2) @(posedge clock);
      preamble_sync <= 1'b1;
      repeat (4) @(posedge clock);
      preamble_sync <= 1'b0;
   endtask
endmodule

//--- sim/telemetry_decommutator_properties.sv
// Purpose: Port assertions of the telemetry decommutator
// Assumes: One clock domain, synchronous active-low reset
// Notes:   A small age counter ties outputs to the word strobe
module telemetry_decommutator_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Inputs
   input wire logic word_sync,
   input wire logic reg_rd,
   // Outputs
   input wire logic [31:0] reg_rdata,
   input wire logic [23:0] checkout_word,
   input wire logic checkout_valid,
   input wire logic [23:0] host_word,
   input wire logic host_valid,
   input wire logic host_scan,
   input wire logic frame_locked,
   input wire logic out_of_limit_alarm
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // ==========================================================
   // Cycles since the word strobe was last high
   logic [3:0] ws_age_r;
   always_ff @(posedge clock) begin
      if (!resetn || word_sync) ws_age_r <= word_sync ? 4'h0 : 4'hf;
      else if (ws_age_r != 4'hf) ws_age_r <= ws_age_r + 4'h1;
   end
   // ==========================================================
   // Properties
   property p_rst;
      disable iff (1'b0) !resetn |=> !host_valid && !checkout_valid && !frame_locked && reg_rdata == 32'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs active after reset");
   property p_word;
      host_valid |-> ws_age_r <= 4'h6;
   endproperty
   a_word: assert property (p_word) else $error("output without word strobe");
   property p_pulse;
      host_valid |=> !host_valid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("host valid longer than one cycle");
   property p_hold;
      !host_valid |-> $stable(host_word);
   endproperty
   a_hold: assert property (p_hold) else $error("host word changed between words");
   property p_addr;
      checkout_valid |-> host_valid && checkout_word[18:9] == {host_word[2:0], host_word[19:13]};
   endproperty
   a_addr: assert property (p_addr) else $error("checkout address differs from host");
   property p_cond;
      checkout_valid |-> host_word[22] == |checkout_word[22:19];
   endproperty
   a_cond: assert property (p_cond) else $error("condition bit not OR of flags");
   property p_flag;
      checkout_valid |-> checkout_word[23] == host_word[23];
   endproperty
   a_flag: assert property (p_flag) else $error("alarm flags disagree");
   property p_scan;
      checkout_valid |-> !host_scan;
   endproperty
   a_scan: assert property (p_scan) else $error("scan word on checkout");
   property p_alarm;
      out_of_limit_alarm && !host_scan |-> host_valid && host_word[23];
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm without flagged word");
   // Main scenarios
   c_eng: cover property (checkout_valid);
   c_scan: cover property (host_valid && host_scan);
   c_lim: cover property (out_of_limit_alarm);
endmodule
bind telemetry_decommutator telemetry_decommutator_checker u_chk (.clock(clock), .resetn(resetn),
   .word_sync(word_sync), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .checkout_word(checkout_word),
   .checkout_valid(checkout_valid), .host_word(host_word), .host_valid(host_valid), .host_scan(host_scan),
   .frame_locked(frame_locked), .out_of_limit_alarm(out_of_limit_alarm));

//--- sim/tb_telemetry_decommutator.sv
// Purpose: Self-checking bench of the telemetry decommutator
// Assumes: Demodulator model drives the word pins
// Notes:   Expected words are rebuilt from position, value and type
module tb_telemetry_decommutator;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, resetn, reg_wr, reg_rd, word_sync, preamble_sync;
   logic host_valid, host_scan, checkout_valid, frame_locked, out_of_limit_alarm, console_valid;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [23:0] word_in, checkout_word, host_word, console_word;
   logic [23:0] hq[$], cq[$], oq[$];
   logic aq[$];
   int bad_count = 0;
   int cmp_count = 0;
   // ==========================================================
   // Design and demodulator
   telemetry_decommutator u_dut (.clock(clock), .resetn(resetn), .word_in(word_in), .word_sync(word_sync),
      .preamble_sync(preamble_sync), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .checkout_word(checkout_word), .checkout_valid(checkout_valid),
      .host_word(host_word), .host_valid(host_valid), .host_scan(host_scan), .console_word(console_word),
      .console_valid(console_valid), .frame_locked(frame_locked), .out_of_limit_alarm(out_of_limit_alarm));
   demod_model u_dem (.clock(clock), .word_in(word_in), .word_sync(word_sync), .preamble_sync(preamble_sync));
   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Collect every output word as it is offered
   always @(posedge clock) begin
      if (host_valid === 1'b1) begin
         hq.push_back(host_word);
         aq.push_back(out_of_limit_alarm);
      end
      if (checkout_valid === 1'b1) cq.push_back(checkout_word);
      if (console_valid === 1'b1) oq.push_back(console_word);
   end
   // ==========================================================
   // Tasks
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
      chk_reg({8'h0, got}, {8'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk_reg(reg_rdata & m, e);
   endtask
   task automatic rst();
      @(posedge clock);
      resetn <= 1'b0;
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      cq.delete();
   endtask
   function automatic logic [8:0] bcd(input int n);
      return {n >= 100, 4'((n % 100) / 10), 4'(n % 10)};
   endfunction
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #20000;
      bad_count++;
      summarize();
   end
   // ==========================================================
   // Main sequence
   initial begin
      logic [6:0] x;
      logic [8:0] b;
      resetn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      void'($urandom(16));
      rst();
      rd(8'h00, '1, 32'h8);
      rd(8'h04, '1, 32'h0);
      rd(8'h10, '1, 32'h0);
      wr(8'h08, 32'h4);
      wr(8'h0c, {18'h0, 7'd20, 7'd10});
      repeat (5) wr(8'h0c, 32'h3f80);
      wr(8'h00, 32'h1a);
      rd(8'h00, '1, 32'h1a);
      u_dem.send(1'b1, 7'h7f);
      u_dem.send(1'b1, 7'h01);
      u_dem.send(1'b1, 7'($urandom % 10));
      u_dem.send(1'b1, 7'($urandom % 20));
      for (int i = 4; i < 10; i++) begin
         x = (i == 4) ? 7'd21 + 7'($urandom % 100) : 7'($urandom);
         b = bcd(x);
         u_dem.send(i != 9, x);
         chk_word(hq.pop_front(), {i == 4, i == 9, 2'b0, 7'(i), b[6:0], 6'h0});
         chk_word(oq.pop_front(), {i == 4, i == 9, 2'b0, 7'(i), x, 6'h0});
         chk_word(cq.pop_front(), {i == 4, 3'h0, i == 9, 3'h0, 7'(i), b});
         chk_reg(aq.pop_front(), 32'(i == 4));
      end
      rd(8'h04, 32'h7f, 32'h11);
      rst();
      u_dem.mark();
      u_dem.send(1'b1, 7'h02);
      for (int i = 0; i < 4; i++) begin
         x = 7'($urandom);
         u_dem.send(1'b1, x);
         chk_word(hq.pop_front(), {1'b0, 3'h2, 7'(i), x, 6'h2});
         chk_word(oq.pop_front(), {1'b0, 3'h2, 7'(i), x, 6'h2});
         chk_reg(host_scan, 32'h1);
      end
      chk_reg(frame_locked, 32'h1);
      chk_reg(cq.size(), 32'h0);
      summarize();
   end
endmodule
